// ### ifa_pkg.sv
// Package for the input fault guards and loop tuning scheduler
// Assumes a 25 MHz mclk and a register port driven by firmware
package ifa_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] IFA_REG_UV_OFF   = 8'h00;
	localparam logic [7:0] IFA_REG_UV_ON    = 8'h04;
	localparam logic [7:0] IFA_REG_UV_RESP  = 8'h08;
	localparam logic [7:0] IFA_REG_OV_OFF   = 8'h0C;
	localparam logic [7:0] IFA_REG_OV_ON    = 8'h10;
	localparam logic [7:0] IFA_REG_OV_RESP  = 8'h14;
	localparam logic [7:0] IFA_REG_DELAY    = 8'h18;
	localparam logic [7:0] IFA_REG_TUNE_CFG = 8'h1C;
	localparam logic [7:0] IFA_REG_CTRL     = 8'h20;
	localparam logic [7:0] IFA_REG_STATUS   = 8'h24;
	localparam logic [7:0] IFA_REG_COEF_P   = 8'h28;
	localparam logic [7:0] IFA_REG_COEF_I   = 8'h2C;
	localparam logic [7:0] IFA_REG_COEF_D   = 8'h30;
	localparam logic [7:0] IFA_REG_TUNE_RES = 8'h34;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int IFA_CTRL_CLEAR   = 0;
	localparam int IFA_CTRL_TRIGGER = 1;
	localparam int IFA_CFG_ONCE     = 2;
	localparam int IFA_CFG_GAIN_LSB = 8;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] IFA_UV_OFF_RST = 16'h0000;
	localparam logic [15:0] IFA_UV_ON_RST  = 16'h0000;
	localparam logic [15:0] IFA_OV_OFF_RST = 16'hFFFF;
	localparam logic [15:0] IFA_OV_ON_RST  = 16'hFFFF;
	localparam logic [15:0] IFA_DELAY_RST  = 16'h0010;
	localparam logic [6:0]  IFA_GAIN_RST   = 7'h32;
	localparam logic [6:0]  IFA_GAIN_MAX   = 7'h64;
	localparam logic [6:0]  IFA_GAIN_MIN   = 7'h0A;
	localparam logic [15:0] IFA_COEF_RST   = 16'h0100;

	// ****************************************
	// Timing
	// ****************************************
	localparam longint IFA_CLK_HZ       = 25_000_000;
	localparam longint IFA_TUNE_MIN_MS  = 50;
	localparam longint IFA_TUNE_MAX_MS  = 200;
	localparam longint IFA_SAMPLE_US    = 10;
	localparam longint IFA_SAMPLE_CYC   = (IFA_SAMPLE_US * IFA_CLK_HZ) / 1_000_000;
	localparam longint IFA_TUNE_CYC     = (IFA_TUNE_MIN_MS * IFA_CLK_HZ + 999) / 1000;
	localparam longint IFA_SEC_CYC      = IFA_CLK_HZ;
	localparam longint IFA_MIN_SECONDS  = 60;
	localparam longint IFA_DELAY_TICK_US = 100;
	localparam longint IFA_DTICK_CYC    = (IFA_DELAY_TICK_US * IFA_CLK_HZ) / 1_000_000;

	// ****************************************
	// Encodings
	// ****************************************
	typedef enum logic [1:0] {
		IFA_RESP_LATCH   = 2'b00,
		IFA_RESP_RESTART = 2'b01,
		IFA_RESP_DELAY   = 2'b10
	} ifa_resp_e;

	typedef enum logic [1:0] {
		IFA_TUNE_OFF    = 2'b00,
		IFA_TUNE_ENABLE = 2'b01,
		IFA_TUNE_SECOND = 2'b10,
		IFA_TUNE_MINUTE = 2'b11
	} ifa_tmode_e;

	localparam logic [1:0] IFA_RESP_RST = 2'b01;
	localparam logic [1:0] IFA_TMODE_RST = 2'b01;

endpackage

// ### ifa_guard_if.sv
// Interface between the top and one input voltage guard
// Assumes one clock shared by both ends
`timescale 1ns/1ps
interface ifa_guard_if;
	logic        sample_vld;
	logic [15:0] vin;
	logic [15:0] off_lvl;
	logic [15:0] on_lvl;
	logic [1:0]  resp;
	logic [15:0] delay_ticks;
	logic        dtick;
	logic        clear;
	logic        reenable;
	logic        shut;
	logic        fault;

	modport guard (input sample_vld, vin, off_lvl, on_lvl, resp, delay_ticks, dtick,
		clear, reenable, output shut, fault);
	modport ctrl (output sample_vld, vin, off_lvl, on_lvl, resp, delay_ticks, dtick,
		clear, reenable, input shut, fault);
endinterface

// ### ifa_guard.sv
// One hysteretic input guard with selectable fault response
// Assumes vin is already on mclk and sample_vld marks fresh readings
`timescale 1ns/1ps
module ifa_guard
	import ifa_pkg::*;
#(
	parameter bit OVER = 1'b0
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Guard link
	ifa_guard_if.guard g
);

	logic        bad_q;
	logic        good;
	logic        bad;
	logic        latch_q;
	logic [15:0] dcnt_q;

	// Hysteresis: trip past off level, recover only past on level
	assign bad  = OVER ? (g.vin > g.off_lvl) : (g.vin < g.off_lvl);
	assign good = OVER ? (g.vin < g.on_lvl) : (g.vin > g.on_lvl);

	// ****************************************
	// Sampled condition
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			bad_q <= 1'b0;
		else if (g.sample_vld)
		begin
			if (bad)
				bad_q <= 1'b1;
			else if (good)
				bad_q <= 1'b0;
		end
	end

	// ****************************************
	// Delay counter for delayed response
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (sys_rst || !bad_q)
			dcnt_q <= 16'h0000;
		else if (g.dtick && dcnt_q != g.delay_ticks)
			dcnt_q <= dcnt_q + 16'h0001;
	end

	// ****************************************
	// Latched shutdown
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			latch_q <= 1'b0;
		else
		begin
			case (g.resp)
				IFA_RESP_LATCH:
				begin
					if (bad_q)
						latch_q <= 1'b1;
					else if (g.clear || g.reenable)
						latch_q <= 1'b0;
				end
				IFA_RESP_DELAY:
				begin
					if (bad_q && dcnt_q == g.delay_ticks)
						latch_q <= 1'b1;
					else if (g.reenable)
						latch_q <= 1'b0;
				end
				default:
					latch_q <= 1'b0;
			endcase
		end
	end

	// Auto-restart follows the hysteretic condition directly
	assign g.shut  = latch_q || (g.resp == IFA_RESP_RESTART && bad_q);
	assign g.fault = bad_q;

endmodule

// ### ifa_top.sv
// Input fault guards and dynamic loop tuning scheduler
// Assumes vin readings come from an on-chip converter on mclk
// and ctrl_pin arrives asynchronously from a board pin
`timescale 1ns/1ps
//
// Contract
// - Turn-on threshold above turn-off gives hysteresis
// - Latching mode: off until clear or re-enable
// - Auto-restart: off below on-level, resume above (code turns off only below off-level, resumes above on-level)
// - Delayed mode: run delay, then latch off
// - Reset response is auto-restart
// - Host programs undervoltage limits and response
// - Overvoltage guard uses same response modes
// - Host programs overvoltage limits and response
// - PID error output drives fixed-frequency PWM
// - Compensator coefficients are host rewritable
// - Tune after ramp, then install coefficients
// - Tuning run lasts between 50 and 200 ms
// - Four tuning modes, periodic ones self-retrigger
// - Default tuning runs on every enable
// - Optional once-per-power-up tuning, reuse coefficients
// - Manual trigger command starts a tuning run
// - Gain scales result, default fifty percent
// - Alert low until clear or re-enable
// - Enable via active-high control pin, clears latch
module ifa_top
	import ifa_pkg::*;
#(
	parameter longint TUNE_CYC = IFA_TUNE_CYC,
	parameter longint SEC_CYC  = IFA_SEC_CYC
)
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// Input voltage reading
	input  wire logic [15:0] vin_code,
	// Control pin and ramp status
	input  wire logic        ctrl_pin,
	input  wire logic        ramp_done,
	// Tuning engine result
	input  wire logic [15:0] meas_p,
	input  wire logic [15:0] meas_i,
	input  wire logic [15:0] meas_d,
	// Outputs
	output logic             out_enable,
	output logic             tune_busy,
	output logic [15:0]      pid_p,
	output logic [15:0]      pid_i,
	output logic [15:0]      pid_d,
	output logic             fault_alert_out_n
);

	// ****************************************
	// Declarations
	// ****************************************
	typedef enum logic [1:0] {
		IFA_ST_IDLE = 2'b00,
		IFA_ST_RUN  = 2'b01,
		IFA_ST_LOAD = 2'b10
	} ifa_tst_e;

	ifa_guard_if uvg ();
	ifa_guard_if ovg ();

	logic [15:0] uv_off_q, uv_on_q, ov_off_q, ov_on_q, delay_q;
	logic [1:0]  uv_resp_q, ov_resp_q, tmode_q;
	logic        once_q;
	logic [6:0]  gain_q;
	logic [15:0] coef_p_q, coef_i_q, coef_d_q;
	logic [2:0]  sts_q;
	logic        alert_q;
	logic [2:0]  ctrl_sync_q;
	logic        ctrl_lvl_q;
	logic        ctrl_prev_q;
	logic        reenable;
	logic        clear_cmd;
	logic        trig_cmd;
	logic [15:0] samp_cnt_q;
	logic        sample_vld;
	logic [15:0] dtick_cnt_q;
	logic        dtick;
	logic        ramp_prev_q;
	logic        ramp_rise;
	logic [31:0] tcnt_q;
	logic [31:0] per_cnt_q;
	logic [5:0]  min_cnt_q;
	logic        period_hit;
	logic        tuned_once_q;
	logic        trig;
	ifa_tst_e    tst_q;
	logic        run_ok;

	// Gain scaling of a measured coefficient, percent of result
	function automatic logic [15:0] ifa_scale(input logic [15:0] v, input logic [6:0] pct);
		logic [22:0] prod;
		prod = 23'(v) * 23'(pct);
		return 16'(prod / 23'(IFA_GAIN_MAX));
	endfunction

	// ****************************************
	// Control pin synchroniser
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			ctrl_sync_q <= 3'b000;
		else
			ctrl_sync_q <= {ctrl_sync_q[1:0], ctrl_pin};
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			ctrl_lvl_q  <= 1'b0;
			ctrl_prev_q <= 1'b0;
		end
		else
		begin
			if (ctrl_sync_q[1] == ctrl_sync_q[2])
				ctrl_lvl_q <= ctrl_sync_q[2];
			ctrl_prev_q <= ctrl_lvl_q;
		end
	end

	assign reenable = ctrl_lvl_q && !ctrl_prev_q;
	assign clear_cmd = reg_wr && reg_addr == IFA_REG_CTRL && reg_wdata[IFA_CTRL_CLEAR];
	assign trig_cmd  = reg_wr && reg_addr == IFA_REG_CTRL && reg_wdata[IFA_CTRL_TRIGGER];

	// ****************************************
	// Sample and delay tick timers
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (sys_rst || sample_vld)
			samp_cnt_q <= 16'h0000;
		else
			samp_cnt_q <= samp_cnt_q + 16'h0001;
	end

	assign sample_vld = samp_cnt_q == 16'(IFA_SAMPLE_CYC - 1);

	always_ff @(posedge mclk)
	begin
		if (sys_rst || dtick)
			dtick_cnt_q <= 16'h0000;
		else
			dtick_cnt_q <= dtick_cnt_q + 16'h0001;
	end

	assign dtick = dtick_cnt_q == 16'(IFA_DTICK_CYC - 1);

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			uv_off_q  <= IFA_UV_OFF_RST;
			uv_on_q   <= IFA_UV_ON_RST;
			ov_off_q  <= IFA_OV_OFF_RST;
			ov_on_q   <= IFA_OV_ON_RST;
			uv_resp_q <= IFA_RESP_RST;
			ov_resp_q <= IFA_RESP_RST;
			delay_q   <= IFA_DELAY_RST;
			tmode_q   <= IFA_TMODE_RST;
			once_q    <= 1'b0;
			gain_q    <= IFA_GAIN_RST;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				IFA_REG_UV_OFF:  uv_off_q  <= reg_wdata[15:0];
				IFA_REG_UV_ON:   uv_on_q   <= reg_wdata[15:0];
				IFA_REG_UV_RESP: uv_resp_q <= reg_wdata[1:0];
				IFA_REG_OV_OFF:  ov_off_q  <= reg_wdata[15:0];
				IFA_REG_OV_ON:   ov_on_q   <= reg_wdata[15:0];
				IFA_REG_OV_RESP: ov_resp_q <= reg_wdata[1:0];
				IFA_REG_DELAY:   delay_q   <= reg_wdata[15:0];
				IFA_REG_TUNE_CFG:
				begin
					tmode_q <= reg_wdata[1:0];
					once_q  <= reg_wdata[IFA_CFG_ONCE];
					// Out-of-range gain is clamped rather than refused
					if (reg_wdata[IFA_CFG_GAIN_LSB +: 7] > IFA_GAIN_MAX)
						gain_q <= IFA_GAIN_MAX;
					else if (reg_wdata[IFA_CFG_GAIN_LSB +: 7] < IFA_GAIN_MIN)
						gain_q <= IFA_GAIN_MIN;
					else
						gain_q <= reg_wdata[IFA_CFG_GAIN_LSB +: 7];
				end
				default: ;
			endcase
		end
	end

	// ****************************************
	// Guards
	// ****************************************
	assign uvg.sample_vld  = sample_vld;
	assign uvg.vin         = vin_code;
	assign uvg.off_lvl     = uv_off_q;
	assign uvg.on_lvl      = uv_on_q;
	assign uvg.resp        = uv_resp_q;
	assign uvg.delay_ticks = delay_q;
	assign uvg.dtick       = dtick;
	assign uvg.clear       = clear_cmd;
	assign uvg.reenable    = reenable;
	assign ovg.sample_vld  = sample_vld;
	assign ovg.vin         = vin_code;
	assign ovg.off_lvl     = ov_off_q;
	assign ovg.on_lvl      = ov_on_q;
	assign ovg.resp        = ov_resp_q;
	assign ovg.delay_ticks = delay_q;
	assign ovg.dtick       = dtick;
	assign ovg.clear       = clear_cmd;
	assign ovg.reenable    = reenable;

	ifa_guard #(.OVER(1'b0)) u_undervolt (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.g       (uvg.guard)
	);

	ifa_guard #(.OVER(1'b1)) u_overvolt (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.g       (ovg.guard)
	);

	// ****************************************
	// Output enable
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			out_enable <= 1'b0;
		else
			out_enable <= ctrl_lvl_q && !uvg.shut && !ovg.shut;
	end

	// ****************************************
	// Fault status and alert
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			sts_q   <= 3'b000;
			alert_q <= 1'b0;
		end
		else
		begin
			// Set wins over a clear in the same cycle
			sts_q[0] <= uvg.fault || (sts_q[0] && !clear_cmd && !reenable);
			sts_q[1] <= ovg.fault || (sts_q[1] && !clear_cmd && !reenable);
			sts_q[2] <= (uvg.shut || ovg.shut) || (sts_q[2] && !clear_cmd && !reenable);
			alert_q  <= uvg.fault || ovg.fault || (alert_q && !clear_cmd && !reenable);
		end
	end

	assign fault_alert_out_n = !alert_q;

	// ****************************************
	// Tuning triggers
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			ramp_prev_q <= 1'b0;
		else
			ramp_prev_q <= ramp_done;
	end

	assign ramp_rise = ramp_done && !ramp_prev_q;

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			per_cnt_q <= 32'h0000_0000;
			min_cnt_q <= 6'h00;
		end
		else if (tmode_q != IFA_TUNE_SECOND && tmode_q != IFA_TUNE_MINUTE)
		begin
			per_cnt_q <= 32'h0000_0000;
			min_cnt_q <= 6'h00;
		end
		else if (per_cnt_q == 32'(SEC_CYC - 1))
		begin
			per_cnt_q <= 32'h0000_0000;
			min_cnt_q <= (min_cnt_q == 6'(IFA_MIN_SECONDS - 1)) ? 6'h00 : min_cnt_q + 6'h01;
		end
		else
			per_cnt_q <= per_cnt_q + 32'h0000_0001;
	end

	assign period_hit = out_enable && per_cnt_q == 32'(SEC_CYC - 1)
		&& (tmode_q == IFA_TUNE_SECOND
		|| min_cnt_q == 6'(IFA_MIN_SECONDS - 1));

	assign run_ok = !(once_q && tuned_once_q);
	assign trig = trig_cmd
		|| (ramp_rise && tmode_q != IFA_TUNE_OFF && run_ok)
		|| period_hit;

	// ****************************************
	// Tuning run sequencer
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			tst_q  <= IFA_ST_IDLE;
			tcnt_q <= 32'h0000_0000;
		end
		else
		begin
			case (tst_q)
				IFA_ST_IDLE:
				begin
					tcnt_q <= 32'h0000_0000;
					if (trig)
						tst_q <= IFA_ST_RUN;
				end
				IFA_ST_RUN:
				begin
					// Triggers here are dropped on purpose
					tcnt_q <= tcnt_q + 32'h0000_0001;
					if (tcnt_q == 32'(TUNE_CYC - 1))
						tst_q <= IFA_ST_LOAD;
				end
				IFA_ST_LOAD:
					tst_q <= IFA_ST_IDLE;
				default:
					tst_q <= IFA_ST_IDLE;
			endcase
		end
	end

	assign tune_busy = tst_q != IFA_ST_IDLE;

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			tuned_once_q <= 1'b0;
		else if (tst_q == IFA_ST_LOAD)
			tuned_once_q <= 1'b1;
	end

	// ****************************************
	// Compensator coefficients
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			coef_p_q <= IFA_COEF_RST;
			coef_i_q <= IFA_COEF_RST;
			coef_d_q <= IFA_COEF_RST;
		end
		else if (tst_q == IFA_ST_LOAD)
		begin
			coef_p_q <= ifa_scale(meas_p, gain_q);
			coef_i_q <= ifa_scale(meas_i, gain_q);
			coef_d_q <= ifa_scale(meas_d, gain_q);
		end
		else if (reg_wr && reg_addr == IFA_REG_COEF_P)
			coef_p_q <= reg_wdata[15:0];
		else if (reg_wr && reg_addr == IFA_REG_COEF_I)
			coef_i_q <= reg_wdata[15:0];
		else if (reg_wr && reg_addr == IFA_REG_COEF_D)
			coef_d_q <= reg_wdata[15:0];
	end

	// Coefficients feed the external PID and PWM datapath
	assign pid_p = coef_p_q;
	assign pid_i = coef_i_q;
	assign pid_d = coef_d_q;

	// ****************************************
	// Read port
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd)
		begin
			case (reg_addr)
				IFA_REG_UV_OFF:   reg_rdata <= {16'h0000, uv_off_q};
				IFA_REG_UV_ON:    reg_rdata <= {16'h0000, uv_on_q};
				IFA_REG_UV_RESP:  reg_rdata <= {30'h0000_0000, uv_resp_q};
				IFA_REG_OV_OFF:   reg_rdata <= {16'h0000, ov_off_q};
				IFA_REG_OV_ON:    reg_rdata <= {16'h0000, ov_on_q};
				IFA_REG_OV_RESP:  reg_rdata <= {30'h0000_0000, ov_resp_q};
				IFA_REG_DELAY:    reg_rdata <= {16'h0000, delay_q};
				IFA_REG_TUNE_CFG: reg_rdata <= {17'h0_0000, gain_q, 5'h00, once_q, tmode_q};
				IFA_REG_STATUS:   reg_rdata <= {27'h000_0000, tune_busy, out_enable, sts_q};
				IFA_REG_COEF_P:   reg_rdata <= {16'h0000, coef_p_q};
				IFA_REG_COEF_I:   reg_rdata <= {16'h0000, coef_i_q};
				IFA_REG_COEF_D:   reg_rdata <= {16'h0000, coef_d_q};
				IFA_REG_TUNE_RES: reg_rdata <= {31'h0000_0000, tuned_once_q};
				default:          reg_rdata <= 32'h0000_0000;
			endcase
		end
		else
			reg_rdata <= 32'h0000_0000;
	end

endmodule

// ### ifa_top_checker.sv
// Concurrent checks on the ports of the input guard and tuning top
// Assumes one mclk domain with synchronous active-high sys_rst
`timescale 1ns/1ps
module ifa_top_checker
	import ifa_pkg::*;
#(
	parameter longint TUNE_CYC = IFA_TUNE_CYC
)
(
	// Clock and reset
	input wire logic        mclk,
	input wire logic        sys_rst,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// Pins and outputs
	input wire logic        ctrl_pin,
	input wire logic        out_enable,
	input wire logic        tune_busy,
	input wire logic [15:0] pid_p,
	input wire logic        fault_alert_out_n
);
	// ****************************************
	// Helper counters
	// ****************************************
	int   busy_cnt_q;
	int   clr_age_q;
	int   pin_hi_q;
	logic pin_prev_q;
	logic clr_wr;
	assign clr_wr = reg_wr && reg_addr == IFA_REG_CTRL && reg_wdata[IFA_CTRL_CLEAR];

	always_ff @(posedge mclk)
	begin
		busy_cnt_q <= (sys_rst || !tune_busy) ? 0 : busy_cnt_q + 1;
	end

	// Saturating so the age never wraps back into the legal window
	always_ff @(posedge mclk)
	begin
		pin_prev_q <= ctrl_pin;
		if (sys_rst || clr_wr || (ctrl_pin && !pin_prev_q))
			clr_age_q <= 0;
		else if (clr_age_q < 15)
			clr_age_q <= clr_age_q + 1;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst || !ctrl_pin)
			pin_hi_q <= 0;
		else if (pin_hi_q < 8)
			pin_hi_q <= pin_hi_q + 1;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// ****************************************
	// Assertions
	// ****************************************
	a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data not zero outside read answer cycle");
	a_status_read_back: assert property (reg_rd && reg_addr == IFA_REG_STATUS |=>
		reg_rdata[3] == $past(out_enable) && reg_rdata[4] == $past(tune_busy))
		else $error("status read does not match outputs");
	a_busy_run_length: assert property ($fell(tune_busy) |-> busy_cnt_q == TUNE_CYC + 1)
		else $error("tuning run length wrong");
	a_trig_starts_run: assert property (!tune_busy && reg_wr && reg_addr == IFA_REG_CTRL
		&& reg_wdata[IFA_CTRL_TRIGGER] |=> tune_busy)
		else $error("manual trigger did not start a run");
	a_coef_change_cause: assert property ($changed(pid_p) |-> $fell(tune_busy)
		|| ($past(reg_wr) && $past(reg_addr) == IFA_REG_COEF_P))
		else $error("coefficient changed without cause");
	a_alert_clear_only: assert property ($rose(fault_alert_out_n) |-> clr_age_q < 8)
		else $error("alert released without clear or re-enable");
	a_shut_raises_alert: assert property ($fell(out_enable) && pin_hi_q == 8
		|-> !fault_alert_out_n)
		else $error("fault shutdown without alert");
	a_pin_low_off: assert property (!ctrl_pin [*8] |-> !out_enable)
		else $error("output on while control pin low");

	c_trigger: cover property (reg_wr && reg_addr == IFA_REG_CTRL && reg_wdata[1]);
	c_alert: cover property ($fell(fault_alert_out_n));
	c_run_end: cover property ($fell(tune_busy));
endmodule

bind ifa_top ifa_top_checker #(.TUNE_CYC(TUNE_CYC)) u_chk (
	.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctrl_pin(ctrl_pin),
	.out_enable(out_enable), .tune_busy(tune_busy), .pid_p(pid_p),
	.fault_alert_out_n(fault_alert_out_n)
);

// ### ifa_ramp_model.sv
// Model of the power stage ramp and tuning measurement engine
// Assumes out_enable from the top; one regulator, never paralleled
`timescale 1ns/1ps
module ifa_ramp_model
#(
	parameter int RAMP_CYC = 30
)
(
	// Clock and reset
	input wire logic   mclk,
	input wire logic   sys_rst,
	// Stage control
	input wire logic   out_enable,
	output logic       ramp_done,
	// Measurement results
	output logic [15:0] meas_p,
	output logic [15:0] meas_i,
	output logic [15:0] meas_d
);
	int ramp_q;
	// Standalone regulator only, so tuning is legal here
	assign meas_p = 16'h0200;
	assign meas_i = 16'h0300;
	assign meas_d = 16'h0400;
	// Ramp restarts from zero on every enable, giving a fresh rise
	always_ff @(posedge mclk)
	begin
		if (sys_rst || !out_enable)
			ramp_q <= 0;
		else if (ramp_q < RAMP_CYC)
			ramp_q <= ramp_q + 1;
	end
	assign ramp_done = (ramp_q == RAMP_CYC);
endmodule

// ### ifa_top_bench.sv
// Self-checking bench for the input guards and tuning scheduler
// Assumes ifa_top, its checker bind and the ramp model compiled first
`timescale 1ns/1ps
module ifa_top_bench;
	import ifa_pkg::*;
	localparam longint TUNE_C = 20;
	localparam longint SEC_C  = 50;
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [15:0] vin_code = 16'h3000;
	logic        ctrl_pin = 1'b0;
	logic        ramp_done, out_enable, tune_busy, fault_alert_out_n;
	logic [15:0] meas_p, meas_i, meas_d, pid_p, pid_i, pid_d;
	int          n_errors = 0;
	int          n_tests = 0;
	logic [31:0] rv;
	int          len;

	ifa_top #(.TUNE_CYC(TUNE_C), .SEC_CYC(SEC_C)) u_dut (
		.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vin_code(vin_code),
		.ctrl_pin(ctrl_pin), .ramp_done(ramp_done), .meas_p(meas_p), .meas_i(meas_i),
		.meas_d(meas_d), .out_enable(out_enable), .tune_busy(tune_busy), .pid_p(pid_p),
		.pid_i(pid_i), .pid_d(pid_d), .fault_alert_out_n(fault_alert_out_n));
	ifa_ramp_model u_ramp (.mclk(mclk), .sys_rst(sys_rst), .out_enable(out_enable),
		.ramp_done(ramp_done), .meas_p(meas_p), .meas_i(meas_i), .meas_d(meas_d));

	initial
	begin
		forever #20 mclk = ~mclk;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic tally_and_finish();
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
			n_errors++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Bounded: a run that never starts or never ends is a mismatch
	task automatic run_len(output int n);
		int k;
		n = 0;
		// Step off the edge so busy is read settled
		#1;
		for (k = 0; k < 100 && tune_busy !== 1'b1; k++) cyc(1);
		for (k = 0; k < 1000 && tune_busy === 1'b1; k++)
		begin
			n++;
			cyc(1);
		end
		if (n == 0 || k == 1000)
		begin
			n_errors++;
			tally_and_finish();
		end
	endtask
	task automatic count_runs(input int span, output int n);
		logic prev;
		n = 0;
		prev = tune_busy;
		repeat (span)
		begin
			cyc(1);
			if (tune_busy === 1'b1 && prev !== 1'b1) n++;
			prev = tune_busy;
		end
	endtask
	task automatic pin_cycle();
		@(posedge mclk) ctrl_pin <= 1'b0;
		cyc(12);
		@(posedge mclk) ctrl_pin <= 1'b1;
	endtask
	task automatic set_vin(input logic [15:0] v, input logic exp_on);
		@(posedge mclk) vin_code <= v;
		cyc(600);
		chk(out_enable, exp_on);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset_values();
		rd(IFA_REG_UV_RESP, rv);
		chk(rv, 32'h0000_0001);
		rd(IFA_REG_OV_RESP, rv);
		chk(rv, 32'h0000_0001);
		rd(IFA_REG_TUNE_CFG, rv);
		chk(rv, 32'h0000_3201);
		chk(pid_p, 16'h0100);
		rd(8'h40, rv);
		chk(rv, 32'h0000_0000);
	endtask
	task automatic t_ramp_tune();
		@(posedge mclk) ctrl_pin <= 1'b1;
		run_len(len);
		chk(len, TUNE_C + 1);
		chk({pid_p, pid_i}, 32'h0100_0180);
		chk(pid_d, 16'h0200);
		wr(IFA_REG_COEF_P, 32'h0000_1234);
		cyc(2);
		chk(pid_p, 16'h1234);
	endtask
	task automatic t_uv_modes();
		wr(IFA_REG_UV_OFF, 32'h0000_1000);
		wr(IFA_REG_UV_ON, 32'h0000_2000);
		set_vin(16'h0800, 1'b0);
		chk(fault_alert_out_n, 1'b0);
		rd(IFA_REG_STATUS, rv);
		chk(rv[1:0], 2'b01);
		set_vin(16'h1800, 1'b0);
		set_vin(16'h2800, 1'b1);
		chk(fault_alert_out_n, 1'b0);
		wr(IFA_REG_CTRL, 32'h0000_0001);
		cyc(100);
		chk(fault_alert_out_n, 1'b1);
		wr(IFA_REG_UV_RESP, 32'h0000_0000);
		set_vin(16'h0800, 1'b0);
		set_vin(16'h3000, 1'b0);
		wr(IFA_REG_CTRL, 32'h0000_0001);
		cyc(100);
		chk(out_enable, 1'b1);
	endtask
	task automatic t_ov_delay();
		wr(IFA_REG_OV_OFF, 32'h0000_C000);
		wr(IFA_REG_OV_ON, 32'h0000_B000);
		wr(IFA_REG_OV_RESP, 32'h0000_0002);
		wr(IFA_REG_DELAY, 32'h0000_0002);
		cyc(100);
		set_vin(16'hD000, 1'b1);
		chk(fault_alert_out_n, 1'b0);
		cyc(2 * IFA_DTICK_CYC + 600);
		chk(out_enable, 1'b0);
		rd(IFA_REG_STATUS, rv);
		chk(rv[2:1], 2'b11);
		set_vin(16'h3000, 1'b0);
		wr(IFA_REG_CTRL, 32'h0000_0001);
		cyc(20);
		chk(out_enable, 1'b0);
		pin_cycle();
		cyc(20);
		chk(out_enable, 1'b1);
	endtask
	task automatic t_manual_gain();
		cyc(100);
		wr(IFA_REG_TUNE_CFG, 32'h0000_6401);
		wr(IFA_REG_CTRL, 32'h0000_0002);
		cyc(5);
		wr(IFA_REG_CTRL, 32'h0000_0002);
		run_len(len);
		chk(len, TUNE_C + 1 - 7);
		chk(pid_p, 16'h0200);
		wr(IFA_REG_TUNE_CFG, 32'h0000_0A01);
		wr(IFA_REG_CTRL, 32'h0000_0002);
		run_len(len);
		chk({pid_p, pid_i}, 32'h0033_004C);
		chk(pid_d, 16'h0066);
	endtask
	task automatic t_modes();
		wr(IFA_REG_TUNE_CFG, 32'h0000_3202);
		count_runs(4 * SEC_C, len);
		chk(len >= 3 && len <= 5, 1'b1);
		wr(IFA_REG_TUNE_CFG, 32'h0000_3200);
		cyc(100);
		pin_cycle();
		count_runs(150, len);
		chk(len, 0);
		wr(IFA_REG_TUNE_CFG, 32'h0000_3203);
		count_runs(61 * SEC_C + 50, len);
		chk(len, 1);
	endtask
	task automatic t_once_power_cycle();
		@(posedge mclk) ctrl_pin <= 1'b0;
		@(posedge mclk) sys_rst <= 1'b1;
		cyc(12);
		@(posedge mclk) sys_rst <= 1'b0;
		wr(IFA_REG_TUNE_CFG, 32'h0000_3205);
		cyc(1);
		chk(pid_i, 16'h0100);
		chk(out_enable, 1'b0);
		@(posedge mclk) ctrl_pin <= 1'b1;
		count_runs(150, len);
		chk(len, 1);
		pin_cycle();
		count_runs(150, len);
		chk(len, 0);
		rd(IFA_REG_TUNE_RES, rv);
		chk(rv[0], 1'b1);
	endtask

	initial
	begin
		cyc(12);
		@(posedge mclk) sys_rst <= 1'b0;
		t_reset_values();
		t_ramp_tune();
		t_uv_modes();
		t_ov_delay();
		t_manual_gain();
		t_modes();
		t_once_power_cycle();
		tally_and_finish();
	end
endmodule
